// >>> logic/ppic_pkg.sv
// Constants, field positions and state layout of the polled interrupt
// controller.
// Assumes one 25 MHz clock and a synchronous active-low reset.
package ppic_pkg;

   localparam int unsigned LEVELS = 8;

   // Command byte and poll byte field positions.
   localparam int unsigned INIT_BIT    = 4;
   localparam int unsigned POLL_STATUS_COMMAND_BIT    = 3;
   localparam int unsigned ROTATE_BIT  = 7;
   localparam int unsigned SPEC_BIT    = 6;
   localparam int unsigned END_BIT     = 5;
   localparam int unsigned SMM_EN_BIT  = 6;
   localparam int unsigned SMM_BIT     = 5;
   localparam int unsigned POLL_BIT    = 2;
   localparam int unsigned STAT_EN_BIT = 1;
   localparam int unsigned STAT_SEL_BIT = 0;
   localparam int unsigned FLAG_BIT    = 7;

   // Lowest priority level after initialisation and reset.
   localparam logic [2:0] BASE_RESET  = 3'h7;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;
   localparam logic [7:0] BYTE_ONES   = 8'hFF;

   typedef struct packed {
      logic [7:0] pending_request_reg;
      logic [7:0] in_service_reg;
      logic [7:0] level_mask_reg;
      logic [7:0] req_prev;
      logic [2:0] bottom_level;
      logic       special_mask_flag;
      logic       status_read_sel;
      logic       poll_armed;
      logic       expect_word_two;
      logic       wr_idle;
      logic       rd_idle;
      logic [7:0] dout;
      logic       doe;
      logic       irq_n;
   } ppic_state_t;

   localparam ppic_state_t STATE_RESET = '{
      pending_request_reg: BYTE_ZERO,
      in_service_reg:      BYTE_ZERO,
      level_mask_reg:      BYTE_ZERO,
      req_prev:            BYTE_ONES,
      bottom_level:        BASE_RESET,
      special_mask_flag:   1'b0,
      status_read_sel:     1'b0,
      poll_armed:          1'b0,
      expect_word_two:     1'b0,
      wr_idle:             1'b1,
      rd_idle:             1'b1,
      dout:                BYTE_ZERO,
      doe:                 1'b0,
      irq_n:               1'b1
   };

endpackage : ppic_pkg

// >>> logic/ppic_ctrl.sv
// Polled eight-level priority interrupt controller with its register port.
// Assumes strobes and request inputs are synchronous to mclk.
//
// Summary of operation
// - Write strobe with select accepts command byte.
// - Read strobe drives pending, service, mask or code.
// - Register select qualifies and steers every access but the second init word.
// - Rising requests latch, resolve, raise interrupt output.
// - Interrupt raised when top request not served.
// - Poll flag in third command arms poll.
// - Poll read clears request, sets service bit.
// - Poll byte: level in 0-2, flag bit 7.
// - End command has select and bits 4,3 zero.
// - Non-specific end clears top service bit.
// - Specific end clears named bit; others nothing.
// - Auto rotate: ended level becomes lowest priority.
// - Rotate specific without end sets bottom level.
// - Rotate specific end sets bottom, clears bit.
// - Select high write loads mask; read returns it.
// - Mask acts on pending bits; on service bits only in special.
// - Masked service bit still blocks outside special.
// - Special mask flag changes only when enabled or on initialisation.
// - Status select changes only when enabled or on initialisation.
// - Select low with bit 4 starts initialisation.
// - Initialisation rearms edges and clears the mask.
// - Initialisation sets level 7 lowest, clears flags.
// - Rising edge sets pending; masked bits held clear.
// - Status choice remembered; poll needs fresh command.
// - Poll wins over status read in one command.
`timescale 1ns/100ps

module ppic_ctrl
   import ppic_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       cs_n,
   input  wire logic       wr_n,
   input  wire logic       rd_n,
   input  wire logic       reg_select,
   input  wire logic [7:0] data_in,
   input  wire logic [7:0] request_inputs,
   output logic      [7:0] data_out,
   output logic            data_oe,
   output logic            irq_out_n
);

   ppic_state_t st;
   ppic_state_t next_st;

   // Finds the first set bit of vec walking from the level just above
   // bottom; bit 3 of the result says whether one was found.
   function automatic logic [3:0] ppic_pick(input logic [7:0] vec,
                                            input logic [2:0] bottom);
      logic [3:0] res;
      logic [2:0] lvl;
      res = 4'h0;
      for (int i = LEVELS; i >= 1; i--) begin
         lvl = bottom + 3'(i);
         if (vec[lvl]) begin
            res = {1'b1, lvl};
         end
      end
      return res;
   endfunction : ppic_pick

   logic       wr_go;
   logic       rd_go;
   logic [3:0] win;
   logic [3:0] blk;
   logic [3:0] top_isr;
   logic [7:0] blocking;
   logic [2:0] win_rank;
   logic [2:0] blk_rank;
   logic       want_irq;
   logic [7:0] rises;

   assign wr_go = !cs_n && !wr_n && st.wr_idle;
   assign rd_go = !cs_n && !rd_n && st.rd_idle;

   // Special mask lets masked in-service levels stop blocking.
   always_comb begin
      if (st.special_mask_flag) begin
         blocking = st.in_service_reg & ~st.level_mask_reg;
      end else begin
         blocking = st.in_service_reg;
      end
   end

   assign win = ppic_pick(st.pending_request_reg & ~st.level_mask_reg,
                          st.bottom_level);
   assign blk = ppic_pick(blocking, st.bottom_level);
   assign top_isr = ppic_pick(st.in_service_reg, st.bottom_level);
   assign win_rank = win[2:0] - st.bottom_level - 3'h1;
   assign blk_rank = blk[2:0] - st.bottom_level - 3'h1;
   assign want_irq = win[3] && (!blk[3] || win_rank < blk_rank);
   assign rises = request_inputs & ~st.req_prev;

   always_comb begin
      next_st = st;
      next_st.wr_idle = cs_n || wr_n;
      next_st.rd_idle = cs_n || rd_n;
      next_st.doe = !cs_n && !rd_n;
      next_st.req_prev = request_inputs;

      // Poll acknowledge and status reads.
      if (rd_go) begin
         if (reg_select) begin
            next_st.dout = st.level_mask_reg;
         end else if (st.poll_armed) begin
            next_st.dout = BYTE_ZERO;
            next_st.dout[FLAG_BIT] = win[3];
            next_st.dout[2:0] = win[2:0];
            next_st.poll_armed = 1'b0;
            if (win[3]) begin
               next_st.pending_request_reg[win[2:0]] = 1'b0;
               next_st.in_service_reg[win[2:0]] = 1'b1;
            end
         end else if (st.status_read_sel) begin
            next_st.dout = st.in_service_reg;
         end else begin
            next_st.dout = st.pending_request_reg;
         end
      end

      // Command writes.
      if (wr_go) begin
         if (st.expect_word_two) begin
            next_st.expect_word_two = 1'b0;
         end else if (reg_select) begin
            next_st.level_mask_reg = data_in;
         end else if (data_in[INIT_BIT]) begin
            next_st.expect_word_two = 1'b1;
            next_st.level_mask_reg = BYTE_ZERO;
            next_st.pending_request_reg = BYTE_ZERO;
            next_st.in_service_reg = BYTE_ZERO;
            next_st.req_prev = BYTE_ONES;
            next_st.bottom_level = BASE_RESET;
            next_st.special_mask_flag = 1'b0;
            next_st.status_read_sel = 1'b0;
            next_st.poll_armed = 1'b0;
         end else if (data_in[POLL_STATUS_COMMAND_BIT]) begin
            if (data_in[SMM_EN_BIT]) begin
               next_st.special_mask_flag = data_in[SMM_BIT];
            end
            if (data_in[STAT_EN_BIT]) begin
               next_st.status_read_sel = data_in[STAT_SEL_BIT];
            end
            next_st.poll_armed = data_in[POLL_BIT];
         end else begin
            case ({data_in[ROTATE_BIT], data_in[SPEC_BIT], data_in[END_BIT]})
               3'h1: begin
                  if (top_isr[3]) begin
                     next_st.in_service_reg[top_isr[2:0]] = 1'b0;
                  end
               end
               3'h3: begin
                  next_st.in_service_reg[data_in[2:0]] = 1'b0;
               end
               3'h5: begin
                  if (top_isr[3]) begin
                     next_st.in_service_reg[top_isr[2:0]] = 1'b0;
                     next_st.bottom_level = top_isr[2:0];
                  end
               end
               3'h6: begin
                  next_st.bottom_level = data_in[2:0];
               end
               3'h7: begin
                  next_st.bottom_level = data_in[2:0];
                  next_st.in_service_reg[data_in[2:0]] = 1'b0;
               end
               default: begin
                  next_st.bottom_level = st.bottom_level;
               end
            endcase
         end
      end

      // New edges set pending bits after any acknowledge clear, so an
      // edge in the acknowledge cycle is kept; masked bits stay clear.
      if (!(wr_go && !st.expect_word_two && !reg_select
            && data_in[INIT_BIT])) begin
         next_st.pending_request_reg =
            (next_st.pending_request_reg | rises);
      end
      next_st.pending_request_reg =
         next_st.pending_request_reg & ~next_st.level_mask_reg;

      next_st.irq_n = !want_irq;
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st <= STATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign data_out  = st.dout;
   assign data_oe   = st.doe;
   assign irq_out_n = st.irq_n;

   // Checks on the register port and the priority logic.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   logic poll_take;
   logic init_take;
   logic body_write;
   logic end_write;
   logic poll_status_command_write;
   assign poll_take = rd_go && !reg_select && st.poll_armed;
   assign body_write = wr_go && !st.expect_word_two && !reg_select;
   assign init_take = body_write && data_in[INIT_BIT];
   assign end_write = body_write && !data_in[INIT_BIT] && !data_in[POLL_STATUS_COMMAND_BIT];
   assign poll_status_command_write = body_write && !data_in[INIT_BIT] && data_in[POLL_STATUS_COMMAND_BIT];

   property p_mask_load;
      wr_go && reg_select && !st.expect_word_two
         |=> st.level_mask_reg == $past(data_in);
   endproperty
   a_mask_load: assert property (p_mask_load)
      else $error("mask write not stored");

   property p_poll_ack;
      poll_take && win[3]
         |=> st.in_service_reg[$past(win[2:0])]
             && st.dout[FLAG_BIT] && !st.poll_armed;
   endproperty
   a_poll_ack: assert property (p_poll_ack)
      else $error("poll read did not acknowledge");

   property p_poll_code;
      poll_take |=> st.dout[2:0] == $past(win[2:0])
                    ##1 (data_out == $past(data_out)) || st.rd_idle;
   endproperty
   a_poll_code: assert property (p_poll_code)
      else $error("poll code wrong or unstable");

   property p_init;
      init_take |=> st.level_mask_reg == BYTE_ZERO
                    && st.bottom_level == BASE_RESET
                    && !st.special_mask_flag && !st.status_read_sel
                    && st.expect_word_two;
   endproperty
   a_init: assert property (p_init)
      else $error("initialisation state wrong");

   property p_masked_clear;
      (st.pending_request_reg & st.level_mask_reg) == BYTE_ZERO;
   endproperty
   a_masked_clear: assert property (p_masked_clear)
      else $error("masked request bit pending");

   property p_no_req_no_irq;
      $past(st.pending_request_reg) == BYTE_ZERO |-> irq_out_n;
   endproperty
   a_no_req_no_irq: assert property (p_no_req_no_irq)
      else $error("interrupt without pending request");

   property p_specific_end;
      body_write && !data_in[POLL_STATUS_COMMAND_BIT] && !data_in[INIT_BIT]
         && data_in[SPEC_BIT] && data_in[END_BIT]
         |=> !st.in_service_reg[$past(data_in[2:0])];
   endproperty
   a_specific_end: assert property (p_specific_end)
      else $error("specific end left bit set");

   property p_rotate_spec;
      body_write && !data_in[POLL_STATUS_COMMAND_BIT] && !data_in[INIT_BIT]
         && data_in[ROTATE_BIT] && data_in[SPEC_BIT]
         |=> st.bottom_level == $past(data_in[2:0]);
   endproperty
   a_rotate_spec: assert property (p_rotate_spec)
      else $error("bottom level not set");

   property p_word_two_ignored;
      wr_go && st.expect_word_two
         |=> $stable(st.level_mask_reg) && !st.expect_word_two;
   endproperty
   a_word_two_ignored: assert property (p_word_two_ignored)
      else $error("second init word not ignored");

   property p_nonspecific_end;
      end_write && !data_in[SPEC_BIT] && data_in[END_BIT] && top_isr[3]
         && !rd_go |=> !st.in_service_reg[$past(top_isr[2:0])];
   endproperty
   a_nonspecific_end: assert property (p_nonspecific_end)
      else $error("non-specific end left bit set");

   property p_auto_rotate;
      end_write && data_in[ROTATE_BIT] && !data_in[SPEC_BIT]
         && data_in[END_BIT] && top_isr[3]
         |=> st.bottom_level == $past(top_isr[2:0]);
   endproperty
   a_auto_rotate: assert property (p_auto_rotate)
      else $error("auto rotate bottom level wrong");

   property p_smm_set;
      poll_status_command_write && data_in[SMM_EN_BIT]
         |=> st.special_mask_flag == $past(data_in[SMM_BIT]);
   endproperty
   a_smm_set: assert property (p_smm_set)
      else $error("special mask flag not written");

   property p_smm_hold;
      poll_status_command_write && !data_in[SMM_EN_BIT] |=> $stable(st.special_mask_flag);
   endproperty
   a_smm_hold: assert property (p_smm_hold)
      else $error("special mask flag changed without enable");

   property p_stat_sel;
      poll_status_command_write && data_in[STAT_EN_BIT]
         |=> st.status_read_sel == $past(data_in[STAT_SEL_BIT]);
   endproperty
   a_stat_sel: assert property (p_stat_sel)
      else $error("status selection not written");

   property p_status_read;
      rd_go && !reg_select && !st.poll_armed
         |=> st.dout == ($past(st.status_read_sel) ? $past(st.in_service_reg)
                         : $past(st.pending_request_reg));
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read returned wrong register");

   property p_poll_disarm;
      rd_go && !reg_select && !wr_go |=> !st.poll_armed;
   endproperty
   a_poll_disarm: assert property (p_poll_disarm)
      else $error("poll still armed after read");

   property p_oe_on;
      !cs_n && !rd_n |=> data_oe;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("data enable not raised during read");

   property p_oe_off;
      cs_n || rd_n |=> !data_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("data enable raised outside read");

   property p_init_clear;
      init_take && !rd_go
         |=> st.pending_request_reg == BYTE_ZERO
             && st.in_service_reg == BYTE_ZERO && !st.poll_armed;
   endproperty
   a_init_clear: assert property (p_init_clear)
      else $error("initialisation left requests set");

endmodule : ppic_ctrl

// >>> tb/ppic_host.sv
// Bus master model that polls the controller over its register port.
// Assumes the controller samples its strobes on the rising edge of mclk.
`timescale 1ns/100ps

module ppic_host (
   input  wire logic       mclk,
   output logic            cs_n,
   output logic            wr_n,
   output logic            rd_n,
   output logic            reg_select,
   output logic [7:0]      data_in,
   input  wire logic [7:0] data_out
);
   initial begin
      cs_n       = 1'b1;
      wr_n       = 1'b1;
      rd_n       = 1'b1;
      reg_select = 1'b0;
      data_in    = 8'h00;
   end

   // Strobe and chip select are low for one sampling edge, then released.
   task automatic wr(input logic sel, input logic [7:0] d);
      @(posedge mclk);
      cs_n       <= 1'b0;
      wr_n       <= 1'b0;
      reg_select <= sel;
      data_in    <= d;
      @(posedge mclk);
      cs_n       <= 1'b1;
      wr_n       <= 1'b1;
      data_in    <= ~d;
   endtask : wr

   task automatic rd(input logic sel, output logic [7:0] d);
      @(posedge mclk);
      cs_n       <= 1'b0;
      rd_n       <= 1'b0;
      reg_select <= sel;
      @(posedge mclk);
      @(posedge mclk);
      d = data_out;
      cs_n       <= 1'b1;
      rd_n       <= 1'b1;
   endtask : rd

endmodule : ppic_host

// >>> tb/tb.sv
// Self-checking bench for the polled interrupt controller.
// Assumes the controller and the bus master model share mclk.
`timescale 1ns/100ps

module tb;
   import ppic_pkg::*;

   logic       mclk           = 1'b0;
   logic       nrst           = 1'b0;
   logic [7:0] request_inputs = 8'h00;
   logic       cs_n, wr_n, rd_n, reg_select, data_oe, irq_out_n;
   logic [7:0] data_in, data_out;
   int         n_fail         = 0;
   int         n_checks       = 0;
   int         cycles         = 0;

   always #20 mclk = ~mclk;

   ppic_ctrl i_ppic_ctrl (.mclk(mclk), .nrst(nrst), .cs_n(cs_n),
      .wr_n(wr_n), .rd_n(rd_n), .reg_select(reg_select),
      .data_in(data_in), .request_inputs(request_inputs),
      .data_out(data_out), .data_oe(data_oe), .irq_out_n(irq_out_n));

   ppic_host i_ppic_host (.mclk(mclk), .cs_n(cs_n), .wr_n(wr_n),
      .rd_n(rd_n), .reg_select(reg_select), .data_in(data_in),
      .data_out(data_out));

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         test_done;
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask : chk

   task automatic rdchk(input logic sel, input logic [7:0] exp);
      logic [7:0] d;
      i_ppic_host.rd(sel, d);
      chk(d, exp);
      @(negedge mclk);
      chk({7'h00, data_oe}, 8'h01);
      @(negedge mclk);
      chk({7'h00, data_oe}, 8'h00);
   endtask : rdchk

   // Allows the edge detector and the registered output to settle.
   task automatic chk_irq(input logic exp);
      repeat (4) @(negedge mclk);
      chk({7'h00, irq_out_n}, {7'h00, exp});
   endtask : chk_irq

   task automatic req(input logic [7:0] v);
      @(posedge mclk);
      request_inputs <= v;
   endtask : req

   task automatic t_init;
      chk_irq(1'b1);
      rdchk(1'b1, 8'h00);
      i_ppic_host.wr(1'b0, 8'h10);
      i_ppic_host.wr(1'b1, 8'hFF);
      rdchk(1'b1, 8'h00);
   endtask : t_init

   task automatic t_poll;
      req(8'h28);
      chk_irq(1'b0);
      rdchk(1'b0, 8'h28);
      i_ppic_host.wr(1'b0, 8'h0C);
      rdchk(1'b0, 8'h83);
      i_ppic_host.wr(1'b0, 8'h0B);
      rdchk(1'b0, 8'h08);
      rdchk(1'b0, 8'h08);
      chk_irq(1'b1);
      i_ppic_host.wr(1'b0, 8'h0F);
      rdchk(1'b0, 8'h85);
      req(8'h00);
   endtask : t_poll

   task automatic t_end;
      i_ppic_host.wr(1'b0, 8'h20);
      rdchk(1'b0, 8'h20);
      i_ppic_host.wr(1'b0, 8'h00);
      i_ppic_host.wr(1'b0, 8'h45);
      i_ppic_host.wr(1'b0, 8'h85);
      rdchk(1'b0, 8'h20);
      i_ppic_host.wr(1'b0, 8'h65);
      rdchk(1'b0, 8'h00);
   endtask : t_end

   task automatic t_mask;
      i_ppic_host.wr(1'b1, 8'h04);
      rdchk(1'b1, 8'h04);
      req(8'h04);
      chk_irq(1'b1);
      i_ppic_host.wr(1'b0, 8'h0A);
      rdchk(1'b0, 8'h00);
      req(8'h00);
      i_ppic_host.wr(1'b1, 8'h00);
   endtask : t_mask

   task automatic t_rotate;
      i_ppic_host.wr(1'b0, 8'hC3);
      req(8'h12);
      chk_irq(1'b0);
      i_ppic_host.wr(1'b0, 8'h0C);
      rdchk(1'b0, 8'h84);
      i_ppic_host.wr(1'b0, 8'hA0);
      req(8'h92);
      i_ppic_host.wr(1'b0, 8'h0C);
      rdchk(1'b0, 8'h87);
      i_ppic_host.wr(1'b0, 8'hE7);
      i_ppic_host.wr(1'b0, 8'h0B);
      rdchk(1'b0, 8'h00);
      req(8'h00);
   endtask : t_rotate

   task automatic t_special;
      i_ppic_host.wr(1'b0, 8'h0C);
      rdchk(1'b0, 8'h81);
      i_ppic_host.wr(1'b1, 8'h02);
      req(8'h08);
      chk_irq(1'b1);
      i_ppic_host.wr(1'b0, 8'h68);
      chk_irq(1'b0);
      i_ppic_host.wr(1'b0, 8'h48);
      chk_irq(1'b1);
      i_ppic_host.wr(1'b0, 8'h28);
      chk_irq(1'b1);
   endtask : t_special

   task automatic t_reinit;
      i_ppic_host.wr(1'b0, 8'h10);
      i_ppic_host.wr(1'b0, 8'h00);
      chk_irq(1'b1);
      rdchk(1'b1, 8'h00);
      req(8'h00);
      req(8'h08);
      chk_irq(1'b0);
   endtask : t_reinit

   initial begin
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      t_init;
      t_poll;
      t_end;
      t_mask;
      t_rotate;
      t_special;
      t_reinit;
      test_done;
   end

endmodule : tb
